// ===== src/spm_top.sv
// System power mode controller with AHB-Lite register slave
`timescale 1ns/1ps
// Summary of operation
// - After reset the system sits in the normal operating mode, never deep off.
// - In normal mode each block is idle or running per its configuration and activity.
// - The secondary core can be idle, running, or forced off by the primary core.
// - Idle submode choice applies only in normal mode with processor and peripherals idle.
// - The fixed-latency task selects the submode that keeps resources on for constant latency.
// - The low-power task selects the submode where the manager picks the cheapest supply.
// - Each entry into normal mode defaults the submode to low power.
// - Resource requests start and stop clock sources and pick regulator modes.
// - Supply voltage is raised for 128 MHz core, 96 MHz flash, USB, debug or radio request.
// - Writing the deep-off register powers down the core and ends all tasks.
// - Deep off wakes on GPIO, comparator, NFC, USB supply, debug start or pin reset.
// - Waking from deep off always performs a full system reset.
// - In deep off only RAM sections marked for retention stay powered.
// - With debug active, deep off is only emulated and debug resources stay powered.
module spm_top (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_clock_en,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Task triggers from the interconnect, same clock
    input wire logic i_fixed_latency_task,
    input wire logic i_low_power_task,
    // Activity levels, same clock
    input wire logic i_cpu_idle,
    input wire logic i_periph_idle,
    input wire logic i_sec_cpu_idle,
    input wire logic i_sec_periph_idle,
    input wire logic i_hfclk_request,
    input wire logic i_lfclk_request,
    input wire logic i_radio_supply_domain_request,
    // Asynchronous wake sources and debug
    input wire logic i_gpio_detect,
    input wire logic i_comparator_wake_detect,
    input wire logic i_nfc_field_sense,
    input wire logic i_usb_supply_pin,
    input wire logic i_debug_active,
    input wire logic i_pin_reset,
    // Power and clock controls
    output logic o_core_power_on,
    output logic o_tasks_abort,
    output logic o_system_reset,
    output logic o_fixed_latency_mode,
    output logic o_voltage_raise,
    output logic o_hfclk_enable,
    output logic o_lfclk_enable,
    output logic o_regulator_low_power,
    output logic o_sec_core_run,
    output logic o_sec_core_power_on,
    output logic [spm_pkg::RAM_SECTIONS-1:0] o_ram_power_on,
    output logic o_debug_resources_on
);
    spm_pkg::spm_mode_type mode;
    spm_pkg::spm_sec_type sec_state;
    logic fixed_latency;
    logic [31:0] config_reg;
    logic [spm_pkg::RAM_SECTIONS-1:0] retain;
    logic [31:0] next_config;
    logic [spm_pkg::RAM_SECTIONS-1:0] next_retain;
    logic [4:0] wake_count;
    logic [5:0] async_sync;
    logic gpio_s, comp_s, nfc_s, usb_s, debug_s, pinrst_s;
    logic debug_d;
    logic wake_any;
    logic all_idle;
    logic vraise;

    // Address phase capture
    logic ap_valid, ap_write;
    logic [7:0] ap_addr;
    logic bus_task_fixed, bus_task_low, bus_deep_off;

    spm_sync #(
        .WIDTH(6)
    ) u_sync (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_enable(i_clock_en),
        .i_async({i_pin_reset, i_debug_active, i_usb_supply_pin, i_nfc_field_sense,
                  i_comparator_wake_detect, i_gpio_detect}),
        .o_sync(async_sync)
    );
    assign {pinrst_s, debug_s, usb_s, nfc_s, comp_s, gpio_s} = async_sync;

    // Bus slave: zero wait states, always OKAY
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else if (i_clock_en && i_hready) begin
            ap_valid <= i_hsel && i_htrans[1] && (i_hsize == 3'h2);
            ap_write <= i_hwrite;
            ap_addr <= i_haddr[7:0];
        end
    end

    wire wr_phase = i_clock_en && ap_valid && ap_write;
    assign bus_task_fixed = wr_phase && ap_addr == spm_pkg::ADDR_TASKS
                            && i_hwdata[spm_pkg::TASK_FIXED_LAT_BIT];
    assign bus_task_low = wr_phase && ap_addr == spm_pkg::ADDR_TASKS
                          && i_hwdata[spm_pkg::TASK_LOW_PWR_BIT];
    assign bus_deep_off = wr_phase && ap_addr == spm_pkg::ADDR_DEEP_OFF
                          && i_hwdata[0];

    // Next register contents, also seen by a read that follows a write back to back
    always_comb begin
        next_config = config_reg;
        next_retain = retain;
        if (wr_phase && ap_addr == spm_pkg::ADDR_CONFIG) begin
            next_config = {28'h0000000, i_hwdata[3:0]};
        end
        if (wr_phase && ap_addr == spm_pkg::ADDR_RETAIN) begin
            next_retain = i_hwdata[spm_pkg::RAM_SECTIONS-1:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            config_reg <= spm_pkg::CONFIG_RESET;
        end else begin
            config_reg <= next_config;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            retain <= spm_pkg::RETAIN_RESET[spm_pkg::RAM_SECTIONS-1:0];
        end else begin
            retain <= next_retain;
        end
    end

    // Read data is registered at the address phase
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_hrdata <= 32'h0000_0000;
        end else if (i_clock_en && i_hready) begin
            o_hrdata <= 32'h0000_0000;
            if (i_hsel && i_htrans[1] && !i_hwrite) begin
                case (i_haddr[7:0])
                    spm_pkg::ADDR_CONFIG: o_hrdata <= next_config;
                    spm_pkg::ADDR_RETAIN: o_hrdata <= {24'h000000, next_retain};
                    spm_pkg::ADDR_STATUS: begin
                        o_hrdata[spm_pkg::ST_MODE_LSB +: 2] <= mode;
                        o_hrdata[spm_pkg::ST_SUBMODE_BIT] <= fixed_latency;
                        o_hrdata[spm_pkg::ST_VRAISE_BIT] <= vraise;
                        o_hrdata[spm_pkg::ST_CLK_REQ_BIT] <= o_hfclk_enable;
                        o_hrdata[spm_pkg::ST_REG_LP_BIT] <= o_regulator_low_power;
                        o_hrdata[spm_pkg::ST_SEC_STATE_LSB +: 2] <= sec_state;
                        o_hrdata[spm_pkg::ST_EMUL_BIT] <= (mode == spm_pkg::SPM_OFF_EMUL);
                    end
                    spm_pkg::ADDR_VREQ: o_hrdata <= {31'h00000000, vraise};
                    default: o_hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Debug session start edge, read only from the second flop
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            debug_d <= 1'b0;
        end else if (i_clock_en) begin
            debug_d <= debug_s;
        end
    end

    assign wake_any = gpio_s || comp_s || nfc_s || usb_s || (debug_s && !debug_d)
                      || pinrst_s;

    // Power mode state machine
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            mode <= spm_pkg::SPM_ON;
            wake_count <= 5'h00;
        end else if (i_clock_en) begin
            case (mode)
                spm_pkg::SPM_ON: begin
                    if (bus_deep_off) begin
                        mode <= debug_s ? spm_pkg::SPM_OFF_EMUL : spm_pkg::SPM_OFF;
                    end
                end
                spm_pkg::SPM_OFF, spm_pkg::SPM_OFF_EMUL: begin
                    if (wake_any) begin
                        mode <= spm_pkg::SPM_WAKE;
                        wake_count <= 5'(spm_pkg::WAKE_RESET_CYCLES - 1);
                    end
                end
                spm_pkg::SPM_WAKE: begin
                    if (wake_count == 5'h00) begin
                        mode <= spm_pkg::SPM_ON;
                    end else begin
                        wake_count <= wake_count - 5'h01;
                    end
                end
                default: mode <= spm_pkg::SPM_ON;
            endcase
        end
    end

    // Idle submode; low power after every entry to normal mode
    assign all_idle = i_cpu_idle && i_periph_idle;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            fixed_latency <= 1'b0;
        end else if (i_clock_en) begin
            if (mode != spm_pkg::SPM_ON) begin
                fixed_latency <= 1'b0;
            end else if (i_low_power_task || bus_task_low) begin
                fixed_latency <= 1'b0;
            end else if (i_fixed_latency_task || bus_task_fixed) begin
                fixed_latency <= 1'b1;
            end
        end
    end

    // Secondary core state
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            sec_state <= spm_pkg::SPM_SEC_IDLE;
        end else if (i_clock_en) begin
            if (config_reg[spm_pkg::CFG_SEC_FORCE_OFF_BIT] && !debug_s) begin
                sec_state <= spm_pkg::SPM_SEC_FORCED_OFF;
            end else if (i_sec_cpu_idle && i_sec_periph_idle) begin
                sec_state <= spm_pkg::SPM_SEC_IDLE;
            end else begin
                sec_state <= spm_pkg::SPM_SEC_RUN;
            end
        end
    end

    assign vraise = config_reg[spm_pkg::CFG_CORE_128_BIT] || config_reg[spm_pkg::CFG_FLASH_96_BIT]
                    || config_reg[spm_pkg::CFG_USB_EN_BIT] || debug_s
                    || i_radio_supply_domain_request;

    // Power, abort and reset outputs, registered
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_core_power_on <= 1'b1;
            o_tasks_abort <= 1'b0;
            o_system_reset <= 1'b0;
            o_sec_core_power_on <= 1'b1;
            o_ram_power_on <= '1;
            o_debug_resources_on <= 1'b0;
        end else if (i_clock_en) begin
            o_core_power_on <= (mode != spm_pkg::SPM_OFF);
            o_tasks_abort <= (mode == spm_pkg::SPM_OFF) || (mode == spm_pkg::SPM_OFF_EMUL);
            o_system_reset <= (mode == spm_pkg::SPM_WAKE);
            o_sec_core_power_on <= sec_state != spm_pkg::SPM_SEC_FORCED_OFF
                                   && mode != spm_pkg::SPM_OFF;
            o_ram_power_on <= (mode == spm_pkg::SPM_OFF) ? retain : '1;
            o_debug_resources_on <= debug_s;
        end
    end

    // Submode and secondary core run outputs, registered
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_fixed_latency_mode <= 1'b0;
            o_sec_core_run <= 1'b0;
        end else if (i_clock_en) begin
            o_fixed_latency_mode <= fixed_latency && mode == spm_pkg::SPM_ON && all_idle;
            o_sec_core_run <= sec_state == spm_pkg::SPM_SEC_RUN && mode == spm_pkg::SPM_ON;
        end
    end

    // Clock source, supply and regulator demand, registered
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_voltage_raise <= 1'b0;
            o_hfclk_enable <= 1'b0;
            o_lfclk_enable <= 1'b0;
            o_regulator_low_power <= 1'b0;
        end else if (i_clock_en) begin
            o_voltage_raise <= vraise && mode != spm_pkg::SPM_OFF;
            o_hfclk_enable <= (mode == spm_pkg::SPM_OFF_EMUL) || (mode == spm_pkg::SPM_ON
                              && (i_hfclk_request || !all_idle || fixed_latency || vraise));
            o_lfclk_enable <= mode != spm_pkg::SPM_OFF && i_lfclk_request;
            o_regulator_low_power <= (mode == spm_pkg::SPM_OFF) || (mode == spm_pkg::SPM_ON
                                     && all_idle && !fixed_latency && !vraise);
        end
    end
endmodule

// ===== src/spm_pkg.sv
// Package with constants and types for the system power mode controller
package spm_pkg;

    localparam int unsigned RAM_SECTIONS = 8;

    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_TASKS = 8'h00;
    localparam logic [7:0] ADDR_DEEP_OFF = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_RETAIN = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_VREQ = 8'h14;

    // Task register bits
    localparam int unsigned TASK_FIXED_LAT_BIT = 0;
    localparam int unsigned TASK_LOW_PWR_BIT = 1;

    // Config register bits
    localparam int unsigned CFG_CORE_128_BIT = 0;
    localparam int unsigned CFG_FLASH_96_BIT = 1;
    localparam int unsigned CFG_USB_EN_BIT = 2;
    localparam int unsigned CFG_SEC_FORCE_OFF_BIT = 3;

    // Status register bit positions
    localparam int unsigned ST_MODE_LSB = 0;
    localparam int unsigned ST_SUBMODE_BIT = 2;
    localparam int unsigned ST_VRAISE_BIT = 3;
    localparam int unsigned ST_CLK_REQ_BIT = 4;
    localparam int unsigned ST_REG_LP_BIT = 5;
    localparam int unsigned ST_SEC_STATE_LSB = 6;
    localparam int unsigned ST_EMUL_BIT = 8;

    // Reset values
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] RETAIN_RESET = 32'h0000_0000;

    // Length of the system reset pulse issued on wakeup, in cycles
    localparam int unsigned WAKE_RESET_CYCLES = 16;

    typedef enum logic [1:0] {
        SPM_ON,
        SPM_OFF,
        SPM_OFF_EMUL,
        SPM_WAKE
    } spm_mode_type;

    typedef enum logic [1:0] {
        SPM_SEC_IDLE,
        SPM_SEC_RUN,
        SPM_SEC_FORCED_OFF
    } spm_sec_type;

endpackage

// ===== src/spm_sync.sv
// Two-flop synchroniser vector for asynchronous wake and debug inputs
`timescale 1ns/1ps
module spm_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_enable,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_clock) begin
                if (i_sys_rst) begin
                    stage1[g] <= 1'b0;
                    o_sync[g] <= 1'b0;
                end else if (i_enable) begin
                    stage1[g] <= i_async[g];
                    o_sync[g] <= stage1[g];
                end
            end
        end
    endgenerate
endmodule

// ===== tb/spm_top_monitor.sv
// Assertion checker watching the power mode controller ports
`timescale 1ns/1ps
module spm_top_monitor (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_clock_en,
    input wire logic i_cpu_idle,
    input wire logic i_periph_idle,
    input wire logic i_hfclk_request,
    input wire logic i_radio_supply_domain_request,
    input wire logic i_gpio_detect,
    input wire logic o_core_power_on,
    input wire logic o_tasks_abort,
    input wire logic o_system_reset,
    input wire logic o_fixed_latency_mode,
    input wire logic o_voltage_raise,
    input wire logic o_hfclk_enable,
    input wire logic o_debug_resources_on,
    input wire logic [spm_pkg::RAM_SECTIONS-1:0] o_ram_power_on
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    logic [7:0] rst_len;
    logic on_run;
    // Counts how long the wake reset has been high
    always_ff @(posedge i_clock) begin
        rst_len <= o_system_reset ? rst_len + 8'h01 : 8'h00;
    end
    assign on_run = o_core_power_on && !o_tasks_abort && !o_system_reset && i_clock_en;
    a_reset_normal_mode: assert property (disable iff (1'b0)
        i_sys_rst && i_clock_en |=> o_core_power_on && !o_tasks_abort) else $error("mode");
    a_submode_needs_idle: assert property (
        o_fixed_latency_mode |-> $past(i_cpu_idle && i_periph_idle)) else $error("submode");
    a_hfclk_on_request: assert property (
        on_run && i_hfclk_request |-> ##[0:3] o_hfclk_enable) else $error("hfclk");
    a_radio_raises_supply: assert property (
        on_run && i_radio_supply_domain_request |-> ##[0:3] o_voltage_raise) else $error("vr");
    a_off_aborts_tasks: assert property (
        !o_core_power_on |-> o_tasks_abort) else $error("abort");
    a_gpio_wakes_off: assert property (
        !o_core_power_on && i_gpio_detect |-> ##[1:8] o_system_reset) else $error("wake");
    a_wake_reset_len: assert property (
        $fell(o_system_reset) |-> rst_len == 8'(spm_pkg::WAKE_RESET_CYCLES)) else $error("len");
    a_wake_low_power: assert property (
        $fell(o_system_reset) |-> o_core_power_on && !o_fixed_latency_mode) else $error("sub");
    a_emul_keeps_power: assert property (
        $rose(o_tasks_abort) && o_debug_resources_on |-> o_core_power_on && (&o_ram_power_on))
        else $error("emul");
    c_fixed_mode: cover property (o_fixed_latency_mode);
    c_wake_done: cover property ($fell(o_system_reset));
    c_emulated: cover property (o_tasks_abort && o_core_power_on);
endmodule
bind spm_top spm_top_monitor spm_top_monitor_i (.*);

// ===== tb/spm_periph_model.sv
// Behavioural model of the cores and peripherals issuing requests
`timescale 1ns/1ps
module spm_periph_model (
    input wire logic i_clock,
    input wire logic i_busy,
    input wire logic i_sec_busy,
    input wire logic [1:0] i_fire,
    output logic o_cpu_idle,
    output logic o_periph_idle,
    output logic o_sec_cpu_idle,
    output logic o_sec_periph_idle,
    output logic o_fixed_latency_task,
    output logic o_low_power_task
);
    initial begin
        o_fixed_latency_task = 1'b0;
        o_low_power_task = 1'b0;
    end
    // Task triggers leave as pulses launched just after an edge
    always @(posedge i_clock) begin
        o_fixed_latency_task <= i_fire[0];
        o_low_power_task <= i_fire[1];
    end
    assign o_cpu_idle = !i_busy;
    assign o_periph_idle = !i_busy;
    assign o_sec_cpu_idle = !i_sec_busy;
    assign o_sec_periph_idle = !i_sec_busy;
endmodule

// ===== tb/spm_top_tb.sv
// Self-checking bench for the system power mode controller
`timescale 1ns/1ps
module spm_top_tb;
    logic clk, rst = 1'b1, hwrite = 1'b0, busy = 1'b0, sec_busy = 1'b0;
    logic hf_req = 1'b0, lf_req = 1'b0, radio_req = 1'b0;
    logic [1:0] htrans = 2'h0, fire = 2'h0;
    logic [5:0] wk = 6'h00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic hready, ci, pi, sci, spi, flt, lpt, core_on, abort, sys_reset, fixed_mode, vraise;
    logic hf_en, lf_en, sec_run, sec_on, dbg_on, reg_lp, hresp;
    logic [7:0] ram_on;
    int fail_count = 0, n_tests = 0, k;
    spm_periph_model spm_periph_model_i (.i_clock(clk), .i_busy(busy), .i_sec_busy(sec_busy),
        .i_fire(fire), .o_cpu_idle(ci), .o_periph_idle(pi), .o_sec_cpu_idle(sci),
        .o_sec_periph_idle(spi), .o_fixed_latency_task(flt), .o_low_power_task(lpt));
    spm_top spm_top_i (.i_clock(clk), .i_sys_rst(rst), .i_clock_en(1'b1), .i_hsel(1'b1),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .i_fixed_latency_task(flt), .i_low_power_task(lpt), .i_cpu_idle(ci),
        .i_periph_idle(pi), .i_sec_cpu_idle(sci), .i_sec_periph_idle(spi),
        .i_hfclk_request(hf_req), .i_lfclk_request(lf_req),
        .i_radio_supply_domain_request(radio_req), .i_gpio_detect(wk[0]),
        .i_comparator_wake_detect(wk[1]), .i_nfc_field_sense(wk[2]),
        .i_usb_supply_pin(wk[3]), .i_debug_active(wk[4]), .i_pin_reset(wk[5]),
        .o_core_power_on(core_on), .o_tasks_abort(abort), .o_system_reset(sys_reset),
        .o_fixed_latency_mode(fixed_mode), .o_voltage_raise(vraise), .o_hfclk_enable(hf_en),
        .o_lfclk_enable(lf_en), .o_regulator_low_power(reg_lp), .o_sec_core_run(sec_run),
        .o_sec_core_power_on(sec_on), .o_ram_power_on(ram_on), .o_debug_resources_on(dbg_on));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // One single word transfer; read data is taken at the data phase's closing edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse(input logic [1:0] f);
        @(posedge clk);
        fire <= f;
        @(posedge clk);
        fire <= 2'h0;
        wt(4);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #50000;
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk("core_on", 32'h1, core_on);
        chk("fixed_mode", 32'h0, fixed_mode);
        bus(1'b0, spm_pkg::ADDR_STATUS, 32'h0);
        chk("status_mode", 32'h0, rd & 32'h7);
        pulse(2'h1);
        chk("fixed_mode", 32'h1, fixed_mode);
        chk("reg_lp", 32'h0, reg_lp);
        pulse(2'h2);
        chk("fixed_mode", 32'h0, fixed_mode);
        pulse(2'h1);
        pulse(2'h3);
        chk("fixed_mode", 32'h0, fixed_mode);
        busy <= 1'b1;
        pulse(2'h1);
        chk("fixed_mode", 32'h0, fixed_mode);
        chk("reg_lp", 32'h0, reg_lp);
        busy <= 1'b0;
        wt(4);
        chk("fixed_mode", 32'h1, fixed_mode);
        bus(1'b1, spm_pkg::ADDR_TASKS, 32'h3);
        wt(4);
        chk("fixed_mode", 32'h0, fixed_mode);
        bus(1'b1, spm_pkg::ADDR_TASKS, 32'h1);
        wt(4);
        chk("fixed_mode", 32'h1, fixed_mode);
        bus(1'b1, spm_pkg::ADDR_TASKS, 32'h2);
        wt(4);
        chk("fixed_mode", 32'h0, fixed_mode);
        hf_req <= 1'b1;
        lf_req <= 1'b1;
        wt(4);
        chk("clk_en", 32'h3, {hf_en, lf_en});
        hf_req <= 1'b0;
        lf_req <= 1'b0;
        wt(4);
        chk("clk_en", 32'h0, {hf_en, lf_en});
        chk("reg_lp", 32'h1, reg_lp);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, spm_pkg::ADDR_CONFIG, (i < 3) ? (32'h1 << i) : 32'h0);
            radio_req <= (i == 3);
            wk[4] <= (i == 4);
            wt(6);
            chk("vraise", 32'h1, vraise);
            bus(1'b0, spm_pkg::ADDR_VREQ, 32'h0);
            chk("vreq", 32'h1, rd);
        end
        wk <= 6'h00;
        wt(6);
        chk("vraise", 32'h0, vraise);
        sec_busy <= 1'b1;
        wt(4);
        bus(1'b0, spm_pkg::ADDR_STATUS, 32'h0);
        chk("sec_state", 32'h40, rd & 32'hC0);
        chk("sec_run", 32'h1, sec_run);
        bus(1'b1, spm_pkg::ADDR_CONFIG, 32'h8);
        wt(4);
        bus(1'b0, spm_pkg::ADDR_STATUS, 32'h0);
        chk("sec_state", 32'h80, rd & 32'hC0);
        chk("sec_power", 32'h0, sec_on);
        bus(1'b1, spm_pkg::ADDR_CONFIG, 32'h0);
        sec_busy <= 1'b0;
        bus(1'b0, spm_pkg::ADDR_RETAIN, 32'h0);
        chk("retain", spm_pkg::RETAIN_RESET, rd);
        bus(1'b1, spm_pkg::ADDR_RETAIN, 32'h5A);
        bus(1'b0, spm_pkg::ADDR_RETAIN, 32'h0);
        chk("retain", 32'h5A, rd);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        for (int s = 0; s < 6; s++) begin
            pulse(2'h1);
            bus(1'b1, spm_pkg::ADDR_DEEP_OFF, 32'h1);
            wt(4);
            chk("core_off", 32'h0, {abort, core_on} ^ 2'h2);
            chk("ram_keep", 32'h5A, ram_on);
            wk[s] <= 1'b1;
            k = 0;
            while (sys_reset !== 1'b1 && k < 20) begin
                @(posedge clk);
                k++;
            end
            wk <= 6'h00;
            k = 0;
            while (sys_reset === 1'b1 && k < 40) begin
                @(posedge clk);
                k++;
            end
            chk("reset_len", spm_pkg::WAKE_RESET_CYCLES, k);
            bus(1'b0, spm_pkg::ADDR_STATUS, 32'h0);
            chk("woken_mode", 32'h0, rd & 32'h7);
        end
        wk[4] <= 1'b1;
        wt(4);
        bus(1'b1, spm_pkg::ADDR_DEEP_OFF, 32'h1);
        wt(4);
        chk("emul_power", 32'h7, {core_on, abort, dbg_on});
        chk("emul_ram", 32'hFF, ram_on);
        bus(1'b0, spm_pkg::ADDR_STATUS, 32'h0);
        chk("emul_mode", 32'h102, rd & 32'h103);
        complete_run();
    end
endmodule
